// >>> core/pvsr_regs.sv
// Vendor interrupt, counter, strap latch and power saving registers of the transceiver.
//
// Summary of operation
// - Bit 15 mirrors status, cleared by read.
// - Duplex mask blocks duplex change interrupts.
// - Speed mask blocks speed change interrupts.
// - Link mask, bit 9, blocks link interrupts.
// - Master mask blocks every interrupt.
// - Duplex change flag latched until read.
// - Speed change flag latched until read.
// - Link change flag latched until read.
// - Status bit and pin follow unmasked flags.
// - Sixteen-bit receive error counter, clear on read.
// - Eight-bit disconnect counter, clear on read.
// - Bits 15..12 hold LED, irq, cable, isolate straps.
// - Bits 11..8 hold RMII, serial, repeater, test straps.
// - Bits 7..5 hold operating mode straps.
// - Bits 4..0 hold PHY address straps.
// - Preamble trimmed by 10 or 20 bits.
// - Drive reduced without link unless disabled.
// - 10M saving enable qualifies preamble trimming.
// - Preamble-normal control forbids any trimming.
`timescale 1ns/1ps
module pvsr_regs (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire pvsr_pkg::pvsr_mgmt_req_s  mgmt_req,
  output logic [15:0]                    mgmt_rdata,
  output logic                           mgmt_rvalid,
  input  wire pvsr_pkg::pvsr_line_state_s line_state,
  input  wire logic                      rx_error_seen,
  input  wire logic                      disconnect_seen,
  input  wire pvsr_pkg::pvsr_strap_s     strap_pins,
  input  wire logic                      tx_10m_saving_enable,
  input  wire logic                      preamble_normal,
  output logic                           mgmt_irq_pin_n,
  output logic [4:0]                     preamble_trim_bits,
  output logic                           tx_drive_reduce
);

  logic                       rd_int;
  logic                       wr_int;
  logic                       rd_rxerr;
  logic                       rd_disc;
  logic                       wr_psave;
  logic [15:0]                rxerr_count;
  logic [7:0]                 disc_count;

  pvsr_pkg::pvsr_line_state_s line_prev_r;
  logic [3:0]                 masks_r;
  logic [3:0]                 masks_nxt;
  logic [2:0]                 flags_r;
  logic [2:0]                 flags_nxt;
  logic [2:0]                 events;
  logic                       irq_stat_r;
  logic                       irq_stat_nxt;
  logic                       irq_pin_n_r;
  logic                       irq_pin_n_nxt;
  pvsr_pkg::pvsr_strap_s      strap_r;
  pvsr_pkg::pvsr_strap_s      strap_nxt;
  logic                       preamble_sel_r;
  logic                       preamble_sel_nxt;
  logic                       drive_dis_r;
  logic                       drive_dis_nxt;
  logic [15:0]                rdata_r;
  logic [15:0]                rdata_nxt;
  logic                       rvalid_r;
  logic                       rvalid_nxt;
  logic [4:0]                 trim_r;
  logic [4:0]                 trim_nxt;
  logic                       reduce_r;
  logic                       reduce_nxt;

  assign rd_int   = mgmt_req.rd && (mgmt_req.addr == pvsr_pkg::OFS_INT_MASK_STATUS);
  assign wr_int   = mgmt_req.wr && (mgmt_req.addr == pvsr_pkg::OFS_INT_MASK_STATUS);
  assign rd_rxerr = mgmt_req.rd && (mgmt_req.addr == pvsr_pkg::OFS_RX_ERR_COUNT);
  assign rd_disc  = mgmt_req.rd && (mgmt_req.addr == pvsr_pkg::OFS_DISC_COUNT);
  assign wr_psave = mgmt_req.wr && (mgmt_req.addr == pvsr_pkg::OFS_POWER_SAVING);

  pvsr_rc_counter #(
    .WIDTH (pvsr_pkg::RX_ERR_CNT_W)
  ) u_rxerr_cnt (
    .clk   (clk),
    .srst  (srst),
    .inc   (rx_error_seen),
    .clr   (rd_rxerr),
    .count (rxerr_count)
  );

  pvsr_rc_counter #(
    .WIDTH (pvsr_pkg::DISC_CNT_W)
  ) u_disc_cnt (
    .clk   (clk),
    .srst  (srst),
    .inc   (disconnect_seen),
    .clr   (rd_disc),
    .count (disc_count)
  );

  // Interrupt group: masks, latched change flags and the status bit.
  always_comb
  begin
    events    = {line_state.duplex ^ line_prev_r.duplex,
                 line_state.speed ^ line_prev_r.speed,
                 line_state.link ^ line_prev_r.link};
    masks_nxt = masks_r;
    if (wr_int)
    begin
      masks_nxt = {mgmt_req.wdata[pvsr_pkg::BIT_DUPLEX_MASK], mgmt_req.wdata[pvsr_pkg::BIT_SPEED_MASK],
                   mgmt_req.wdata[pvsr_pkg::BIT_LINK_MASK], mgmt_req.wdata[pvsr_pkg::BIT_MASTER_MASK]};
    end
    // A set in the clearing cycle wins, so no change is lost.
    flags_nxt    = (rd_int ? 3'h0 : flags_r) | events;
    irq_stat_nxt = !masks_nxt[0] &&
                   |(flags_nxt & ~masks_nxt[3:1]);
    // The pin has a flop of its own, so no gate sits between a register and the board.
    irq_pin_n_nxt = !irq_stat_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // Loading the live state avoids a false change flag after reset.
      line_prev_r <= line_state;
      masks_r     <= {4{pvsr_pkg::MASK_RESET}};
      flags_r     <= 3'h0;
      irq_stat_r  <= 1'b0;
      irq_pin_n_r <= 1'b1;
    end
    else
    begin
      line_prev_r <= line_state;
      masks_r     <= masks_nxt;
      flags_r     <= flags_nxt;
      irq_stat_r  <= irq_stat_nxt;
      irq_pin_n_r <= irq_pin_n_nxt;
    end
  end

  // Straps are sampled on every clock while reset is held, so the last level before release stays.
  always_comb
  begin
    strap_nxt = srst ? strap_pins : strap_r;
  end

  always_ff @(posedge clk)
  begin
    strap_r <= strap_nxt;
  end

  // Power saving group and its outputs.
  always_comb
  begin
    preamble_sel_nxt = preamble_sel_r;
    drive_dis_nxt    = drive_dis_r;
    if (wr_psave)
    begin
      preamble_sel_nxt = mgmt_req.wdata[pvsr_pkg::BIT_PREAMBLE_SEL];
      drive_dis_nxt    = mgmt_req.wdata[pvsr_pkg::BIT_TX_DRIVE_DIS];
    end
    trim_nxt = pvsr_pkg::TRIM_NONE;
    if (tx_10m_saving_enable && !preamble_normal)
    begin
      trim_nxt = preamble_sel_r ? pvsr_pkg::TRIM_SHORT : pvsr_pkg::TRIM_LONG;
    end
    reduce_nxt = !drive_dis_r && !line_state.link;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      preamble_sel_r <= pvsr_pkg::PSAVE_RESET;
      drive_dis_r    <= pvsr_pkg::PSAVE_RESET;
      trim_r         <= pvsr_pkg::TRIM_NONE;
      reduce_r       <= 1'b0;
    end
    else
    begin
      preamble_sel_r <= preamble_sel_nxt;
      drive_dis_r    <= drive_dis_nxt;
      trim_r         <= trim_nxt;
      reduce_r       <= reduce_nxt;
    end
  end

  // Read path returns the value before any clearing effect of the same read.
  always_comb
  begin
    rdata_nxt = 16'h0000;
    unique case (mgmt_req.addr)
      pvsr_pkg::OFS_INT_MASK_STATUS:
      begin
        rdata_nxt[pvsr_pkg::BIT_IRQ_PENDING] = irq_stat_r;
        rdata_nxt[pvsr_pkg::BIT_DUPLEX_MASK] = masks_r[3];
        rdata_nxt[pvsr_pkg::BIT_SPEED_MASK]  = masks_r[2];
        rdata_nxt[pvsr_pkg::BIT_LINK_MASK]   = masks_r[1];
        rdata_nxt[pvsr_pkg::BIT_MASTER_MASK] = masks_r[0];
        rdata_nxt[pvsr_pkg::BIT_DUPLEX_CHG]  = flags_r[2];
        rdata_nxt[pvsr_pkg::BIT_SPEED_CHG]   = flags_r[1];
        rdata_nxt[pvsr_pkg::BIT_LINK_CHG]    = flags_r[0];
        rdata_nxt[pvsr_pkg::BIT_IRQ_STATUS]  = irq_stat_r;
      end
      pvsr_pkg::OFS_RX_ERR_COUNT:
      begin
        rdata_nxt = rxerr_count;
      end
      pvsr_pkg::OFS_DISC_COUNT:
      begin
        rdata_nxt = {8'h00, disc_count};
      end
      pvsr_pkg::OFS_STRAP_LATCH:
      begin
        rdata_nxt = strap_r;
      end
      pvsr_pkg::OFS_POWER_SAVING:
      begin
        rdata_nxt[pvsr_pkg::BIT_PREAMBLE_SEL] = preamble_sel_r;
        rdata_nxt[pvsr_pkg::BIT_TX_DRIVE_DIS] = drive_dis_r;
      end
      default:
      begin
        rdata_nxt = 16'h0000;
      end
    endcase
    // Between reads the last word stays on the bus.
    if (!mgmt_req.rd)
    begin
      rdata_nxt = rdata_r;
    end
    rvalid_nxt = mgmt_req.rd;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign mgmt_rdata         = rdata_r;
  assign mgmt_rvalid        = rvalid_r;
  assign mgmt_irq_pin_n     = irq_pin_n_r;
  assign preamble_trim_bits = trim_r;
  assign tx_drive_reduce    = reduce_r;

  AST_PENDING_MIRRORS: assert property (@(posedge clk) disable iff (srst)
    mgmt_rvalid && $past(rd_int) |-> mgmt_rdata[15] == mgmt_rdata[0])
    else $error("Pending bit differs from status bit.");

  AST_MASTER_BLOCKS: assert property (@(posedge clk) disable iff (srst)
    masks_r[0] |-> mgmt_irq_pin_n)
    else $error("Interrupt pin active with master mask set.");

  AST_DUPLEX_MASKED: assert property (@(posedge clk) disable iff (srst)
    masks_r[3] && flags_r[2] && !(flags_r[1] && !masks_r[2]) && !(flags_r[0] && !masks_r[1]) |-> !irq_stat_r)
    else $error("Interrupt raised by a masked duplex change.");

  AST_LINK_FLAG_SET: assert property (@(posedge clk) disable iff (srst)
    $changed(line_state.link) && !$past(srst) |=> flags_r[0])
    else $error("Link change not latched.");

  AST_FLAG_CLEARED: assert property (@(posedge clk) disable iff (srst)
    rd_int && events == 3'h0 |=> flags_r == 3'h0 && !irq_stat_r)
    else $error("Flags not cleared by read.");

  AST_PIN_RAISED: assert property (@(posedge clk) disable iff (srst)
    !masks_r[0] && !masks_r[1] && flags_r[0] && !rd_int && !wr_int |=> !mgmt_irq_pin_n)
    else $error("Unmasked flag did not raise the pin.");

  AST_DISC_UPPER_ZERO: assert property (@(posedge clk) disable iff (srst)
    mgmt_rvalid && $past(rd_disc) |-> mgmt_rdata[15:8] == 8'h00)
    else $error("Disconnect register upper bits not zero.");

  AST_RXERR_KEPT: assert property (@(posedge clk) disable iff (srst)
    rd_rxerr && rx_error_seen |=> rxerr_count == 16'h0001)
    else $error("Error counted during clearing read lost.");

  AST_LINK_KEPT: assert property (@(posedge clk) disable iff (srst)
    rd_int && events[0] |=> flags_r[0])
    else $error("Link change during clearing read lost.");

  AST_TRIM_VALUE: assert property (@(posedge clk) disable iff (srst)
    !srst && tx_10m_saving_enable && !preamble_normal && !preamble_sel_r |=> preamble_trim_bits == 5'h14)
    else $error("Long preamble trim not applied.");

  AST_TRIM_NORMAL: assert property (@(posedge clk) disable iff (srst)
    !srst && preamble_normal |=> preamble_trim_bits == 5'h00)
    else $error("Preamble trimmed while normal count is requested.");

  AST_DRIVE_REDUCE: assert property (@(posedge clk) disable iff (srst)
    !srst && !drive_dis_r && !line_state.link |=> tx_drive_reduce)
    else $error("Drive not reduced without link.");

  AST_STRAP_HELD: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> $stable(strap_r))
    else $error("Strap latch changed outside reset.");

endmodule

// >>> core/pvsr_pkg.sv
// Package with offsets, field positions, reset values and carrier types of the vendor status registers.
package pvsr_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;

  localparam logic [4:0] OFS_INT_MASK_STATUS = 5'h15;
  localparam logic [4:0] OFS_RX_ERR_COUNT    = 5'h16;
  localparam logic [4:0] OFS_DISC_COUNT      = 5'h17;
  localparam logic [4:0] OFS_STRAP_LATCH     = 5'h18;
  localparam logic [4:0] OFS_POWER_SAVING    = 5'h1d;

  localparam int unsigned BIT_IRQ_PENDING  = 15;
  localparam int unsigned BIT_DUPLEX_MASK  = 11;
  localparam int unsigned BIT_SPEED_MASK   = 10;
  localparam int unsigned BIT_LINK_MASK    = 9;
  localparam int unsigned BIT_MASTER_MASK  = 8;
  localparam int unsigned BIT_DUPLEX_CHG   = 4;
  localparam int unsigned BIT_SPEED_CHG    = 3;
  localparam int unsigned BIT_LINK_CHG     = 2;
  localparam int unsigned BIT_IRQ_STATUS   = 0;
  localparam int unsigned BIT_PREAMBLE_SEL = 11;
  localparam int unsigned BIT_TX_DRIVE_DIS = 9;

  localparam logic       MASK_RESET       = 1'b1;
  localparam logic       PSAVE_RESET      = 1'b0;
  localparam int unsigned RX_ERR_CNT_W    = 16;
  localparam int unsigned DISC_CNT_W      = 8;

  localparam logic [4:0] TRIM_NONE  = 5'h00;
  localparam logic [4:0] TRIM_SHORT = 5'h0a;
  localparam logic [4:0] TRIM_LONG  = 5'h14;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [4:0]        addr;
    logic [15:0]       wdata;
  } pvsr_mgmt_req_s;

  typedef struct packed {
    logic duplex;
    logic speed;
    logic link;
  } pvsr_line_state_s;

  // Field order matches bit 15 down to bit 0 of the strap latch register.
  typedef struct packed {
    logic       led_style_pin;
    logic       irq_pin_strap;
    logic       cable_state_pin;
    logic       isolate_strap;
    logic       reduced_mii_strap;
    logic       serial_10m_strap;
    logic       repeater_strap;
    logic       test_mode_strap;
    logic [2:0] op_mode_strap;
    logic [4:0] phy_addr_strap;
  } pvsr_strap_s;

endpackage

// >>> core/pvsr_rc_counter.sv
// Read-clearing event counter that saturates at its top value.
`timescale 1ns/1ps
module pvsr_rc_counter #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             inc,
  input  wire logic             clr,
  output logic [WIDTH-1:0]      count
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  // An increment in the clearing cycle is kept as the first count of the next period.
  always_comb
  begin
    count_nxt = count_r;
    if (clr)
    begin
      count_nxt = {{(WIDTH-1){1'b0}}, inc};
    end
    else if (inc && !(&count_r))
    begin
      count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count_r <= '0;
    end
    else
    begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

endmodule

// >>> verif/pvsr_mgmt_model.sv
// Station management controller model that issues register reads and writes.
`timescale 1ns/1ps
module pvsr_mgmt_model (
  input  wire logic                clk,
  output pvsr_pkg::pvsr_mgmt_req_s mgmt_req,
  input  wire logic [15:0]         mgmt_rdata,
  input  wire logic                mgmt_rvalid
);
  initial mgmt_req = '{rd: 1'b0, wr: 1'b0, addr: 5'h00, wdata: 16'h0000};

  // Index and data are inverted when released, so a stale value never looks valid.
  task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
    @(posedge clk);
    mgmt_req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk);
    mgmt_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    #1;
    ok = w ? !mgmt_rvalid : mgmt_rvalid;
    q = mgmt_rdata;
  endtask
endmodule

// >>> verif/phy_vendor_status_regs_tb.sv
// Self-checking testbench of the vendor status registers against a behavioural model.
`timescale 1ns/1ps
module phy_vendor_status_regs_tb;
  logic                       clk = 1'b0;
  logic                       srst = 1'b1;
  pvsr_pkg::pvsr_mgmt_req_s   mgmt_req;
  logic [15:0]                mgmt_rdata;
  logic                       mgmt_rvalid;
  pvsr_pkg::pvsr_line_state_s line_state;
  logic                       rx_error_seen;
  logic                       disconnect_seen;
  pvsr_pkg::pvsr_strap_s      strap_pins;
  logic                       tx_10m_saving_enable;
  logic                       preamble_normal;
  logic                       mgmt_irq_pin_n;
  logic [4:0]                 preamble_trim_bits;
  logic                       tx_drive_reduce;
  int                         errors = 0;
  int                         tests_run = 0;
  int                         nrx = 0;
  int                         ndc = 0;
  logic [31:0]                rnd;
  logic [15:0]                sv;
  logic [15:0]                q;
  logic [2:0]                 fl = 3'h0;
  logic [3:0]                 mk = 4'hf;

  always #5 clk = ~clk;

  pvsr_regs pvsr_regs_i (.clk(clk), .srst(srst), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .line_state(line_state), .rx_error_seen(rx_error_seen),
    .disconnect_seen(disconnect_seen), .strap_pins(strap_pins), .tx_10m_saving_enable(tx_10m_saving_enable),
    .preamble_normal(preamble_normal), .mgmt_irq_pin_n(mgmt_irq_pin_n),
    .preamble_trim_bits(preamble_trim_bits), .tx_drive_reduce(tx_drive_reduce));
  pvsr_mgmt_model pvsr_mgmt_model_i (.clk(clk), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Model view of the interrupt register; status follows masks and flags.
  function automatic logic [15:0] e15();
    logic s;
    s = !mk[0] && |(fl & ~mk[3:1]);
    return {s, 3'h0, mk, 3'h0, fl, 1'b0, s};
  endfunction

  task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("Error at %0t: value %h, expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("Error at %0t: bit %b, expected %b", $time, g, e);
    end
  endtask

  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] r);
    logic ok;
    pvsr_mgmt_model_i.access(w, a, d, r, ok);
    chk_bit(ok, 1'b1);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] r;
    acc(1'b0, a, 16'h0000, r);
    chk_val(r, e);
  endtask

  task automatic final_report();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end

  initial
  begin
    rnd = lfsr(32'h6597);
    sv = rnd[15:0];
    strap_pins = sv;
    line_state = rnd[18:16];
    rx_error_seen = 1'b0;
    disconnect_seen = 1'b0;
    tx_10m_saving_enable = 1'b0;
    preamble_normal = 1'b0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    strap_pins <= ~sv;
    @(posedge clk);
    #1;
    chk_bit(mgmt_irq_pin_n, 1'b1);
    rchk(pvsr_pkg::OFS_INT_MASK_STATUS, e15());
    rchk(pvsr_pkg::OFS_RX_ERR_COUNT, 16'h0000);
    rchk(pvsr_pkg::OFS_DISC_COUNT, 16'h0000);
    rchk(pvsr_pkg::OFS_STRAP_LATCH, sv);
    rchk(pvsr_pkg::OFS_POWER_SAVING, 16'h0000);
    rchk(5'h00, 16'h0000);
    // Every mask setting against every kind of change.
    for (int m = 0; m < 16; m++)
    begin
      mk = m[3:0];
      acc(1'b1, pvsr_pkg::OFS_INT_MASK_STATUS, {4'hf, mk, 8'hff}, q);
      for (int b = 0; b < 3; b++)
      begin
        @(posedge clk);
        line_state[b] <= !line_state[b];
        fl[b] = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        q = e15();
        chk_bit(mgmt_irq_pin_n, !q[0]);
        rchk(pvsr_pkg::OFS_INT_MASK_STATUS, q);
        fl = 3'h0;
        chk_bit(mgmt_irq_pin_n, 1'b1);
      end
    end
    // Events arriving with a clearing read are kept for the next read.
    fork
      rchk(pvsr_pkg::OFS_INT_MASK_STATUS, e15());
      begin
        @(posedge clk);
        line_state.link <= !line_state.link;
        disconnect_seen <= 1'b1;
        @(posedge clk);
        disconnect_seen <= 1'b0;
      end
    join
    fl = 3'b001;
    ndc = 1;
    rchk(pvsr_pkg::OFS_INT_MASK_STATUS, e15());
    fl = 3'h0;
    for (int k = 0; k < 4; k++)
    begin
      for (int c = 0; c < 60; c++)
      begin
        rnd = lfsr(rnd);
        @(posedge clk);
        rx_error_seen <= rnd[0];
        disconnect_seen <= rnd[1];
        nrx += rnd[0];
        ndc += rnd[1];
      end
      @(posedge clk);
      rx_error_seen <= 1'b0;
      disconnect_seen <= 1'b0;
      rchk(pvsr_pkg::OFS_DISC_COUNT, ndc[15:0]);
      ndc = 0;
      fork
        rchk(pvsr_pkg::OFS_RX_ERR_COUNT, nrx[15:0]);
        begin
          @(posedge clk);
          rx_error_seen <= 1'b1;
          @(posedge clk);
          rx_error_seen <= 1'b0;
        end
      join
      nrx = 1;
    end
    rchk(pvsr_pkg::OFS_RX_ERR_COUNT, 16'h0001);
    rchk(pvsr_pkg::OFS_DISC_COUNT, 16'h0000);
    // All combinations of the power saving controls, reserved bits written high.
    for (int p = 0; p < 32; p++)
    begin
      acc(1'b1, pvsr_pkg::OFS_POWER_SAVING, {4'hf, p[2], 1'b1, p[3], 9'h1ff}, q);
      @(posedge clk);
      tx_10m_saving_enable <= p[0];
      preamble_normal <= p[1];
      line_state.link <= p[4];
      repeat (2) @(posedge clk);
      #1;
      chk_val({11'h000, preamble_trim_bits}, (p[0] && !p[1]) ? (p[2] ? 16'h000a : 16'h0014) : 16'h0000);
      chk_bit(tx_drive_reduce, !p[3] && !p[4]);
      rchk(pvsr_pkg::OFS_POWER_SAVING, {4'h0, p[2], 1'b0, p[3], 9'h000});
    end
    final_report();
  end
endmodule
